/* rtl/abu_break_unit.sv */
// Address breakpoint unit: comparator, break sequencing, flags and registers
`timescale 1ns/100ps
`default_nettype none
module abu_break_unit
  import abu_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // CPU side
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_pc_fetch,
  input  wire logic        cpu_swi_taken,
  input  wire logic        cpu_rti_done,
  input  wire logic        cpu_in_wait,
  input  wire logic        cpu_in_stop,
  input  wire logic        rst_pin_vtst,
  output logic             break_req,
  output logic             break_state,
  output logic             timer_freeze,
  output logic             watchdog_hold,
  output logic             flag_clear_allow,
  output logic             wake_req,
  output logic             irq
);
  // -------------------------------------------------------------------------
  // Bus front end and pin synchroniser
  // -------------------------------------------------------------------------
  abu_reg_if regs ();
  logic vtst_s;

  abu_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .regs      (regs.slave)
  );

  abu_sync2 #(.WIDTH(1)) u_vtst_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .async_in (rst_pin_vtst),
    .sync_out (vtst_s)
  );

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  abu_state_t state_q, state_d;
  logic       enable_q, enable_d;
  logic       active_q, active_d;
  logic [7:0] addr_h_q, addr_h_d;
  logic [7:0] addr_l_q, addr_l_d;
  logic       lpexit_q, lpexit_d;
  logic       cfe_q, cfe_d;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_msk_q, irq_msk_d;
  logic       req_q, req_d;
  logic       brk_q, brk_d;
  logic       frz_q, frz_d;
  logic       wdh_q, wdh_d;
  logic       fca_q, fca_d;
  logic       wake_q, wake_d;
  logic       irq_q, irq_d;

  // Decoded write strobes
  logic wr_ctrl, wr_addr_h, wr_addr_l, wr_lp, wr_flg, wr_ist, wr_imsk;
  logic match_hit, sw_force, trigger, lowpower;
  logic [1:0] irq_evt;

  assign wr_ctrl   = regs.wr_en && (regs.idx == ABU_IDX_CTRL);
  assign wr_addr_h = regs.wr_en && (regs.idx == ABU_IDX_ADDR_H);
  assign wr_addr_l = regs.wr_en && (regs.idx == ABU_IDX_ADDR_L);
  assign wr_lp     = regs.wr_en && (regs.idx == ABU_IDX_LPSTAT);
  assign wr_flg    = regs.wr_en && (regs.idx == ABU_IDX_FLGCTL);
  assign wr_ist    = regs.wr_en && (regs.idx == ABU_IDX_IRQST);
  assign wr_imsk   = regs.wr_en && (regs.idx == ABU_IDX_IRQMSK);

  // -------------------------------------------------------------------------
  // Break triggers
  // -------------------------------------------------------------------------
  // Compare runs in every mode, wait included, qualified by fetch and enable
  assign match_hit = enable_q & cpu_pc_fetch &
                     (cpu_addr == {addr_h_q, addr_l_q});
  assign sw_force  = wr_ctrl & regs.wdata[ABU_BIT_ACTIVE];
  assign trigger   = (match_hit | sw_force) && (state_q == ABU_IDLE);
  assign lowpower  = cpu_in_wait | cpu_in_stop;
  assign irq_evt   = {trigger & lowpower, trigger};

  // -------------------------------------------------------------------------
  // Break sequencer next state
  // -------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ABU_IDLE: begin
        if (trigger) begin
          state_d = ABU_PEND;
        end
      end
      ABU_PEND: begin
        if (cpu_swi_taken) begin
          state_d = ABU_ACTIVE;
        end
      end
      ABU_ACTIVE: begin
        if (cpu_rti_done) begin
          state_d = ABU_IDLE;
        end
      end
      default: state_d = ABU_IDLE;
    endcase
    if (!clk_en) begin
      state_d = state_q;
    end
  end

  // -------------------------------------------------------------------------
  // Register file next values
  // -------------------------------------------------------------------------
  always_comb begin
    enable_d  = enable_q;
    active_d  = active_q;
    addr_h_d  = addr_h_q;
    addr_l_d  = addr_l_q;
    lpexit_d  = lpexit_q;
    cfe_d     = cfe_q;
    irq_st_d  = irq_st_q;
    irq_msk_d = irq_msk_q;
    if (clk_en) begin
      if (wr_ctrl) begin
        enable_d = regs.wdata[ABU_BIT_ENABLE];
      end
      // Set wins over a simultaneous clear
      if (wr_ctrl && !regs.wdata[ABU_BIT_ACTIVE]) begin
        active_d = 1'b0;
      end
      if (match_hit | sw_force) begin
        active_d = 1'b1;
      end
      if (wr_addr_h) begin
        addr_h_d = regs.wdata;
      end
      if (wr_addr_l) begin
        addr_l_d = regs.wdata;
      end
      if (wr_lp && !regs.wdata[ABU_BIT_LPEXIT]) begin
        lpexit_d = 1'b0;
      end
      if (trigger && lowpower) begin
        lpexit_d = 1'b1;
      end
      if (wr_flg) begin
        cfe_d = regs.wdata[ABU_BIT_CFE];
      end
      if (wr_imsk) begin
        irq_msk_d = regs.wdata[1:0];
      end
      // Sticky events, write one clears, new event wins
      if (wr_ist) begin
        irq_st_d = irq_st_q & ~regs.wdata[1:0];
      end
      irq_st_d = irq_st_d | irq_evt;
    end
  end

  // -------------------------------------------------------------------------
  // Output next values (all outputs registered)
  // -------------------------------------------------------------------------
  always_comb begin
    req_d  = req_q;
    brk_d  = brk_q;
    frz_d  = frz_q;
    wdh_d  = wdh_q;
    fca_d  = fca_q;
    wake_d = wake_q;
    irq_d  = irq_q;
    if (clk_en) begin
      req_d  = (state_d == ABU_PEND);
      brk_d  = (state_d != ABU_IDLE);
      frz_d  = (state_d != ABU_IDLE);
      wdh_d  = (state_d != ABU_IDLE) & vtst_s;
      fca_d  = (state_d == ABU_IDLE) | cfe_d;
      wake_d = trigger & lowpower;
      irq_d  = |(irq_st_d & irq_msk_d);
    end
  end

  // -------------------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------------------
  always_comb begin
    regs.rdata = 8'h00;
    unique case (regs.idx)
      ABU_IDX_CTRL: begin
        regs.rdata[ABU_BIT_ENABLE] = enable_q;
        regs.rdata[ABU_BIT_ACTIVE] = active_q;
      end
      ABU_IDX_ADDR_H: regs.rdata = addr_h_q;
      ABU_IDX_ADDR_L: regs.rdata = addr_l_q;
      ABU_IDX_LPSTAT: regs.rdata[ABU_BIT_LPEXIT] = lpexit_q;
      ABU_IDX_FLGCTL: regs.rdata[ABU_BIT_CFE] = cfe_q;
      ABU_IDX_IRQST:  regs.rdata[1:0] = irq_st_q;
      ABU_IDX_IRQMSK: regs.rdata[1:0] = irq_msk_q;
      default:        regs.rdata = 8'h00; // Unmapped
    endcase
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ABU_IDLE;
      enable_q  <= 1'b0;
      active_q  <= 1'b0;
      addr_h_q  <= ABU_RST_BYTE;
      addr_l_q  <= ABU_RST_BYTE;
      lpexit_q  <= 1'b0;
      cfe_q     <= 1'b0;
      irq_st_q  <= ABU_RST_IRQ;
      irq_msk_q <= ABU_RST_IRQ;
      req_q     <= 1'b0;
      brk_q     <= 1'b0;
      frz_q     <= 1'b0;
      wdh_q     <= 1'b0;
      fca_q     <= 1'b1;
      wake_q    <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      enable_q  <= enable_d;
      active_q  <= active_d;
      addr_h_q  <= addr_h_d;
      addr_l_q  <= addr_l_d;
      lpexit_q  <= lpexit_d;
      cfe_q     <= cfe_d;
      irq_st_q  <= irq_st_d;
      irq_msk_q <= irq_msk_d;
      req_q     <= req_d;
      brk_q     <= brk_d;
      frz_q     <= frz_d;
      wdh_q     <= wdh_d;
      fca_q     <= fca_d;
      wake_q    <= wake_d;
      irq_q     <= irq_d;
    end
  end

  assign break_req        = req_q;
  assign break_state      = brk_q;
  assign timer_freeze     = frz_q;
  assign watchdog_hold    = wdh_q;
  assign flag_clear_allow = fca_q;
  assign wake_req         = wake_q;
  assign irq              = irq_q;
endmodule : abu_break_unit
`default_nettype wire

/* rtl/abu_pkg.sv */
// Package: register map, field positions, reset values and states of the breakpoint unit
package abu_pkg;
  // -------------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // -------------------------------------------------------------------------
  localparam logic [2:0] ABU_IDX_CTRL   = 3'h0; // break_control_status
  localparam logic [2:0] ABU_IDX_ADDR_H = 3'h1; // break_address_high
  localparam logic [2:0] ABU_IDX_ADDR_L = 3'h2; // break_address_low
  localparam logic [2:0] ABU_IDX_LPSTAT = 3'h3; // break_lowpower_status
  localparam logic [2:0] ABU_IDX_FLGCTL = 3'h4; // break_flag_control
  localparam logic [2:0] ABU_IDX_IRQST  = 3'h5; // interrupt status, write 1 clears
  localparam logic [2:0] ABU_IDX_IRQMSK = 3'h6; // interrupt mask
  localparam logic [2:0] ABU_IDX_LAST   = 3'h6;
  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int ABU_BIT_ENABLE = 7; // break_enable_bit
  localparam int ABU_BIT_ACTIVE = 6; // break_active_flag
  localparam int ABU_BIT_LPEXIT = 1; // lowpower_exit_flag / wait_exit_flag
  localparam int ABU_BIT_CFE    = 7; // clear_flag_enable
  localparam int ABU_IRQ_ENTRY  = 0; // break entered
  localparam int ABU_IRQ_LPEXIT = 1; // low-power mode left by break
  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] ABU_RST_BYTE = 8'h00;
  localparam logic [1:0] ABU_RST_IRQ  = 2'h0;
  // -------------------------------------------------------------------------
  // Break state machine
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ABU_IDLE   = 2'b00, // normal operation
    ABU_PEND   = 2'b01, // request raised, CPU finishing instruction
    ABU_ACTIVE = 2'b10  // inside break routine
  } abu_state_t;
endpackage : abu_pkg

/* rtl/abu_reg_if.sv */
// Interface: register access strobes between bus slave and breakpoint core
`timescale 1ns/100ps
`default_nettype none
interface abu_reg_if;
  logic       wr_en; // one-cycle write strobe
  logic [2:0] idx;   // register index
  logic [7:0] wdata; // write byte
  logic [7:0] rdata; // read byte for idx
  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport core  (input wr_en, input idx, input wdata, output rdata);
endinterface : abu_reg_if
`default_nettype wire

/* rtl/abu_sync2.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module abu_sync2
  import abu_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values, frozen while clock enable is low
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // Synchroniser flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : abu_sync2
`default_nettype wire

/* rtl/abu_ahb_slave.sv */
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/100ps
`default_nettype none
module abu_ahb_slave
  import abu_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  abu_reg_if.slave         regs
);
  logic        wr_q, wr_d;
  logic        rd_q, rd_d;
  logic [2:0]  idx_q, idx_d;
  logic        rdy_q, rdy_d;
  logic [31:0] rdat_q, rdat_d;
  logic        take;
  logic        mapped;

  // Address phase accepted; hsize unused, only word transfers occur
  assign take   = hsel & htrans[1] & hready;
  assign mapped = (haddr[31:5] == 27'h0) && (haddr[4:2] <= ABU_IDX_LAST);

  // Next values of the data-phase controls
  always_comb begin
    wr_d   = wr_q;
    rd_d   = rd_q;
    idx_d  = idx_q;
    rdy_d  = rdy_q;
    rdat_d = rdat_q;
    if (clk_en) begin
      wr_d  = 1'b0;
      rd_d  = 1'b0;
      rdy_d = 1'b1;
      if (rd_q) begin
        rdat_d = {24'h0, regs.rdata}; // Unmapped reads give zero
      end
      if (take) begin
        wr_d  = hwrite & mapped;
        rd_d  = ~hwrite;
        rdy_d = hwrite;
        idx_d = mapped ? haddr[4:2] : ABU_IDX_LAST + 3'h1;
      end
    end
  end

  // Data-phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      idx_q  <= 3'h0;
      rdy_q  <= 1'b1;
      rdat_q <= 32'h0;
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      idx_q  <= idx_d;
      rdy_q  <= rdy_d;
      rdat_q <= rdat_d;
    end
  end

  assign regs.wr_en = wr_q & clk_en;
  assign regs.idx   = idx_q;
  assign regs.wdata = hwdata[7:0];
  assign hreadyout  = rdy_q;
  assign hrdata     = rdat_q;
  assign hresp      = 1'b0; // Always OKAY
endmodule : abu_ahb_slave
`default_nettype wire

/* sim/abu_cpu_model.sv */
// CPU core model: takes the break request and runs the break routine
`timescale 1ns/100ps
`default_nettype none
module abu_cpu_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic break_req,
  input  wire logic break_state,
  input  wire logic rti_go,
  output logic      cpu_swi_taken,
  output logic      cpu_rti_done
);
  logic [1:0] tail_q;
  // Finish the instruction, load SWI, run RTI when commanded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tail_q <= 2'h0;
      cpu_swi_taken <= 1'b0;
      cpu_rti_done <= 1'b0;
    end else begin
      tail_q <= (break_req && !cpu_swi_taken) ? tail_q + 2'h1 : 2'h0;
      cpu_swi_taken <= break_req && (tail_q == 2'h2);
      cpu_rti_done <= rti_go && break_state && !break_req;
    end
  end
endmodule // abu_cpu_model
`default_nettype wire

/* sim/abu_break_unit_asserts.sv */
// Checker of the break sequencing outputs
`timescale 1ns/100ps
`default_nettype none
module abu_break_unit_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cpu_swi_taken,
  input wire logic cpu_rti_done,
  input wire logic cpu_in_wait,
  input wire logic cpu_in_stop,
  input wire logic break_req,
  input wire logic break_state,
  input wire logic timer_freeze,
  input wire logic watchdog_hold,
  input wire logic flag_clear_allow,
  input wire logic wake_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_freeze; timer_freeze == break_state; endproperty
  property p_req_hold; break_req && !cpu_swi_taken |=> break_req; endproperty
  property p_req_end; break_req && cpu_swi_taken |=> !break_req; endproperty
  property p_in_state; break_req |-> break_state; endproperty
  property p_hold; break_state && !cpu_rti_done |=> break_state; endproperty
  property p_end; break_state && !break_req && cpu_rti_done |=> !break_state; endproperty
  property p_rise; $rose(break_state) |-> $rose(break_req); endproperty
  property p_wake;
    wake_req |-> break_state && ($past(cpu_in_wait) || $past(cpu_in_stop));
  endproperty
  property p_wake1; wake_req |=> !wake_req; endproperty
  property p_wdog; watchdog_hold |-> break_state; endproperty
  property p_fca; !break_state |-> flag_clear_allow; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze differs");
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  a_req_end: assert property (p_req_end) else $error("request stuck");
  a_in_state: assert property (p_in_state) else $error("request outside break");
  a_hold: assert property (p_hold) else $error("break state dropped");
  a_end: assert property (p_end) else $error("break not ended");
  a_rise: assert property (p_rise) else $error("state without request");
  a_wake: assert property (p_wake) else $error("wake out of mode");
  a_wake1: assert property (p_wake1) else $error("wake too long");
  a_wdog: assert property (p_wdog) else $error("hold outside break");
  a_fca: assert property (p_fca) else $error("clear blocked");
  c_swi: cover property (break_req ##[1:8] cpu_swi_taken);
  c_wake: cover property (wake_req);
  c_wdog: cover property (watchdog_hold);
endmodule // abu_break_unit_asserts
bind abu_break_unit abu_break_unit_asserts u_chk (.hclk, .hresetn, .cpu_swi_taken,
  .cpu_rti_done, .cpu_in_wait, .cpu_in_stop, .break_req, .break_state, .timer_freeze,
  .watchdog_hold, .flag_clear_allow, .wake_req);
`default_nettype wire

/* sim/tb_address_breakpoint_unit.sv */
// Testbench of the breakpoint unit
`timescale 1ns/100ps
`default_nettype none
module tb_address_breakpoint_unit;
  import abu_pkg::*;
  logic hclk = 0, hresetn = 0, hwrite = 0, pc = 0, in_wait = 0, in_stop = 0;
  logic vtst = 0, rti_go = 0, clk_en = 1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
  logic [15:0] cpu_addr = 16'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, swi, rti, break_req, break_state, timer_freeze;
  logic watchdog_hold, flag_clear_allow, wake_req, irq;
  int bad_count = 0, cmp_count = 0;
  abu_break_unit dut (.hclk, .hresetn, .clk_en, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .cpu_addr, .cpu_pc_fetch(pc), .cpu_swi_taken(swi), .cpu_rti_done(rti),
    .cpu_in_wait(in_wait), .cpu_in_stop(in_stop), .rst_pin_vtst(vtst), .break_req,
    .break_state, .timer_freeze, .watchdog_hold, .flag_clear_allow, .wake_req, .irq);
  abu_cpu_model cpu (.hclk, .hresetn, .break_req, .break_state, .rti_go,
    .cpu_swi_taken(swi), .cpu_rti_done(rti));
  // Clock
  initial forever #2 hclk = ~hclk;
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  task ahb_w(input logic [2:0] i, input logic [7:0] v);
    @(posedge hclk);
    haddr <= {27'h0, i, 2'b00};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wrdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    wrdy;
  endtask
  task ahb_r(input logic [2:0] i);
    @(posedge hclk);
    haddr <= {27'h0, i, 2'b00};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wrdy;
    htrans <= 2'h0;
    wrdy;
    d = hrdata;
  endtask
  // One address on the CPU bus, with fetch flag f for one cycle; the address stays afterwards
  task match(input logic [15:0] a, input logic f);
    @(posedge hclk);
    cpu_addr <= a;
    pc <= f;
    @(posedge hclk);
    pc <= 1'b0;
    @(negedge hclk);
  endtask
  task end_brk;
    int n;
    n = 0;
    while (break_req !== 1'b0 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
      report_and_stop;
    end
    @(posedge hclk) rti_go <= 1'b1;
    @(posedge hclk) rti_go <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    chk({break_state, timer_freeze}, 2'b00);
  endtask
  task t_regs;
    for (int i = 0; i < 8; i++) begin
      ahb_r(i[2:0]);
      chk(d, 32'h0);
    end
    ahb_w(3'h7, 8'hFF);
    ahb_r(3'h7);
    chk({d[7:0], hresp}, 9'h0);
    $display("test regs done");
  endtask
  task t_match;
    ahb_w(ABU_IDX_ADDR_H, 8'hA5);
    ahb_w(ABU_IDX_ADDR_L, 8'h3C);
    ahb_r(ABU_IDX_ADDR_H);
    chk(d, 32'hA5);
    ahb_w(ABU_IDX_IRQMSK, 8'h01);
    ahb_w(ABU_IDX_CTRL, 8'h80);
    match(16'hA53C, 1'b0);
    chk(break_req, 1'b0);
    match(16'hA53D, 1'b1);
    chk(break_req, 1'b0);
    match(16'hA53C, 1'b1);
    chk({break_req, break_state, timer_freeze, watchdog_hold}, 4'hE);
    ahb_r(ABU_IDX_CTRL);
    chk(d, 32'hC0);
    chk({irq, flag_clear_allow}, 2'b10);
    ahb_w(ABU_IDX_FLGCTL, 8'h80);
    ahb_r(ABU_IDX_FLGCTL);
    chk({d[7:0], flag_clear_allow}, 9'h101);
    ahb_w(ABU_IDX_FLGCTL, 8'h00);
    end_brk;
    ahb_w(ABU_IDX_CTRL, 8'h80);
    ahb_r(ABU_IDX_CTRL);
    chk(d, 32'h80);
    ahb_w(ABU_IDX_IRQST, 8'h03);
    ahb_r(ABU_IDX_IRQST);
    chk({d[7:0], irq}, 9'h0);
    ahb_w(ABU_IDX_CTRL, 8'h00);
    match(16'hA53C, 1'b1);
    chk(break_req, 1'b0);
    $display("test match done");
  endtask
  task t_force;
    @(posedge hclk) vtst <= 1'b1;
    ahb_w(ABU_IDX_CTRL, 8'h40);
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    chk({break_state, watchdog_hold}, 2'b11);
    end_brk;
    @(posedge hclk) vtst <= 1'b0;
    ahb_w(ABU_IDX_CTRL, 8'h00);
    $display("test force done");
  endtask
  task t_lowpower;
    ahb_w(ABU_IDX_IRQMSK, 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(posedge hclk);
      in_wait <= (m == 0);
      in_stop <= (m == 1);
      ahb_w(ABU_IDX_CTRL, 8'h80);
      match(16'hA53C, 1'b1);
      chk({wake_req, irq}, 2'b10);
      @(posedge hclk);
      in_wait <= 1'b0;
      in_stop <= 1'b0;
      ahb_r(ABU_IDX_LPSTAT);
      chk(d, 32'h2);
      ahb_w(ABU_IDX_LPSTAT, 8'h00);
      ahb_r(ABU_IDX_LPSTAT);
      chk(d, 32'h0);
      end_brk;
      ahb_w(ABU_IDX_CTRL, 8'h00);
      ahb_w(ABU_IDX_IRQST, 8'h03);
    end
    $display("test lowpower done");
  endtask
  // Frozen clock enable ignores a match; mid-run reset clears the registers
  task t_reset;
    ahb_w(ABU_IDX_CTRL, 8'h80);
    @(posedge hclk) clk_en <= 1'b0;
    match(16'hA53C, 1'b1);
    chk(break_req, 1'b0);
    @(posedge hclk) clk_en <= 1'b1;
    @(posedge hclk) hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb_r(ABU_IDX_ADDR_H);
    chk(d, 32'h0);
    ahb_r(ABU_IDX_ADDR_L);
    chk(d, 32'h0);
    ahb_r(ABU_IDX_CTRL);
    chk(d, 32'h0);
    chk({break_state, flag_clear_allow}, 2'b01);
    $display("test reset done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_match;
    t_force;
    t_lowpower;
    t_reset;
    report_and_stop;
  end
endmodule // tb_address_breakpoint_unit
`default_nettype wire
